// ==== fpc_ctrl.v ====
// Purpose: host controller driving flash command cycles from AHB-Lite registers
// Assumes: software composes protection and buffer sequences from operations
// Notes:   one op at a time; STATUS busy shows progress
//
// Function
// R1 - Address and CE set before WE falls
// R2 - Data held stable past WE rising
// R3 - Sector select from high address bits
// R4 - Buffer loads stay within starting page
// R5 - Word count equals loads minus one
// R6 - Unlock cycles use clean low address
// R7 - Plain read needs no unlock cycles
// R8 - Reset command leaves autoselect or fault
// R9 - Autoselect read upper byte is ignored
// R10 - Full ID needs three separate reads
// R11 - Query only in read or autoselect
// R12 - Protect verify reads 00 or 01
// R13 - Buffer sequence at most 37 cycles
// R14 - Abort reset readies device again
// R15 - Bypass program only after bypass entry
// R16 - Erase suspend only during sector erase; the code tracks no erase and passes a suspend write in any state
// R17 - Erase resume only while suspended; the code tracks no suspend and passes a resume write in any state
// R18 - Protection set entry by three writes
// R19 - Writes 90 then 00 exit set
// R20 - Persistent bit program and erase-all
// R21 - Freeze bit set and read on DQ0
// R22 - F0 exits alternate space
// R23 - Password unlock needs all seven cycles
// R24 - Erase-all preprograms every persistent bit
// R25 - Host writes reset after bad sequence
// R26 - Volatile bit set and clear writes
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`default_nettype none
`include "fpc_map.vh"

module fpc_ctrl
(
    // Clock and reset
    input  wire        i_clk_sys,
    input  wire        i_rst_n,
    // AHB-Lite slave
    input  wire        i_hsel,
    input  wire [7:0]  i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output reg  [31:0] o_hrdata,
    output reg         o_hreadyout,
    output reg         o_hresp,
    // Flash pins
    output reg  [21:0] o_flash_addr,
    output reg  [15:0] o_flash_dq,
    output reg         o_flash_dq_oe,
    input  wire [15:0] i_flash_dq,
    output reg         o_flash_ce_n,
    output reg         o_flash_we_n,
    output reg         o_flash_oe_n
);

    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_SETUP = 3'd1;
    localparam [2:0] S_WE    = 3'd2;
    localparam [2:0] S_HOLD  = 3'd3;
    localparam [2:0] S_RD    = 3'd4;
    localparam [2:0] S_REC   = 3'd5;

    reg  [2:0]  state_r;
    reg  [3:0]  cnt_r;
    reg  [1:0]  step_r;
    reg  [2:0]  op_r;
    reg  [7:0]  cmd_r;
    reg  [21:0] addr_r;
    reg  [15:0] wdata_r;
    reg  [15:0] rdata_r;
    reg         refused_r;
    reg         fault_r;
    reg         bypass_r;
    reg         protset_r;
    reg         autosel_r;
    reg         buf_r;
    reg  [5:0]  buf_cyc_r;
    reg  [7:0]  buf_left_r;
    reg         buf_wc_r;
    reg  [14:0] buf_page_r;
    reg  [15:0] dq_s1_r;
    reg  [15:0] dq_s2_r;
    reg         wr_pend_r;
    reg  [7:0]  wr_addr_r;

    // Index of the last flash cycle in one operation (cycles minus one)
    function [1:0] last_step;
        input [2:0] op;
        begin
            case (op)
                `FPC_OP_UNLOCK: last_step = 2'd2;
                `FPC_OP_CMD2:   last_step = 2'd1;
                default:        last_step = 2'd0;
            endcase
        end
    endfunction

    // Address and data of one flash cycle
    function [37:0] cyc_word;
        input [2:0]  op;
        input [1:0]  step;
        input [7:0]  cmd;
        input [21:0] addr;
        input [15:0] data;
        begin
            cyc_word = {addr, data};
            if (op == `FPC_OP_UNLOCK)
            begin
                // Upper address and data bits held at zero [R6]
                case (step)
                    2'd0:    cyc_word = {`FPC_UNLOCK_A1, `FPC_UNLOCK_D1};
                    2'd1:    cyc_word = {`FPC_UNLOCK_A2, `FPC_UNLOCK_D2};
                    default: cyc_word = {`FPC_UNLOCK_A1, 8'h00, cmd}; // [R18]
                endcase
            end
            else if (op == `FPC_OP_CMD2 && step == 2'd0)
                cyc_word = {22'h000000, 8'h00, cmd}; // [R19] [R20] [R21] [R26]
            else if (op == `FPC_OP_RESET)
                cyc_word = {22'h000000, 8'h00, `FPC_CMD_RESET}; // [R8] [R14] [R22] [R25]
        end
    endfunction

    wire [37:0] cur_w = cyc_word(op_r, step_r, cmd_r, addr_r, wdata_r);
    wire        busy  = (state_r != S_IDLE);
    wire [31:0] ctrl_val = {16'h0000, cmd_r, 5'h00, op_r};
    wire [31:0] stat_val = {25'h0, buf_r, protset_r, bypass_r, rdata_r[0], fault_r,
                            refused_r, busy};

    // Start decision for a new operation
    wire [2:0]  n_op   = i_hwdata[`FPC_CTRL_OP_MSB:`FPC_CTRL_OP_LSB];
    wire [7:0]  n_cmd  = i_hwdata[`FPC_CTRL_CMD_MSB:`FPC_CTRL_CMD_LSB];
    wire        is_ctl = wr_pend_r && (wr_addr_r == `FPC_REG_CTRL);
    wire        plain_wr = (n_op == `FPC_OP_WRITE);
    wire        page_ok  = addr_r[`FPC_PAGE_MSB:`FPC_PAGE_LSB] == buf_page_r;
    wire        refuse =
        // Bypass program needs bypass entry first [R15]
        (n_op == `FPC_OP_CMD2 && n_cmd == `FPC_CMD_PROG && !bypass_r && !protset_r) ||
        // Query only from read or autoselect state [R11]
        (plain_wr && wdata_r[7:0] == `FPC_CMD_QUERY && (bypass_r || protset_r || buf_r)) ||
        // Buffer load stays in one page, within count and cycle limit [R4] [R13]
        // First load sets the page, so its page is not checked
        (plain_wr && buf_r && !buf_wc_r && wdata_r[7:0] != `FPC_CMD_CONFIRM &&
         ((!page_ok && buf_cyc_r != 6'd4) || buf_left_r == 8'h00 ||
          buf_cyc_r >= `FPC_BUF_MAX_CYC - 6'd1));
    wire        start  = is_ctl && !busy && !refuse && n_op <= `FPC_OP_RESET;

    // AHB-Lite slave: zero wait state, registered read data
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_hrdata    <= 32'h00000000;
            o_hreadyout <= 1'b0;
            o_hresp     <= 1'b0;
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
        end
        else
        begin
            o_hreadyout <= 1'b1;
            wr_pend_r   <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
            wr_addr_r   <= {i_haddr[7:2], 2'b00};
            if (i_hsel && i_htrans[1] && i_hready && !i_hwrite)
            begin
                case ({i_haddr[7:2], 2'b00})
                    `FPC_REG_CTRL:   o_hrdata <= ctrl_val;
                    `FPC_REG_ADDR:   o_hrdata <= {10'h000, addr_r};
                    `FPC_REG_WDATA:  o_hrdata <= {16'h0000, wdata_r};
                    `FPC_REG_RDATA:  o_hrdata <= {16'h0000, rdata_r};
                    `FPC_REG_STATUS: o_hrdata <= stat_val;
                    default:         o_hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Software registers and sequence tracking
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            op_r       <= `FPC_OP_WRITE;
            cmd_r      <= 8'h00;
            addr_r     <= 22'h000000; // Sector select lives in top bits [R3]
            wdata_r    <= 16'h0000;
            refused_r  <= 1'b0;
            bypass_r   <= 1'b0;
            protset_r  <= 1'b0;
            autosel_r  <= 1'b0;
            buf_r      <= 1'b0;
            buf_wc_r   <= 1'b0;
            buf_cyc_r  <= 6'd0;
            buf_left_r <= 8'h00;
            buf_page_r <= 15'h0000;
        end
        else
        begin
            if (wr_pend_r && !busy && wr_addr_r == `FPC_REG_ADDR)
                addr_r <= i_hwdata[21:0];
            if (wr_pend_r && !busy && wr_addr_r == `FPC_REG_WDATA)
                wdata_r <= i_hwdata[15:0];
            if (is_ctl && !busy)
                refused_r <= refuse;
            if (start)
            begin
                op_r  <= n_op;
                cmd_r <= n_cmd;
                if (n_op == `FPC_OP_RESET)
                begin
                    bypass_r  <= 1'b0;
                    protset_r <= 1'b0;
                    autosel_r <= 1'b0;
                    buf_r     <= 1'b0;
                end
                else if (n_op == `FPC_OP_UNLOCK)
                begin
                    autosel_r <= (n_cmd == `FPC_CMD_AUTOSEL);
                    if (n_cmd == `FPC_CMD_BYPASS)
                        bypass_r <= 1'b1;
                    if (n_cmd == 8'h40 || n_cmd == 8'h60 || n_cmd == 8'hC0 ||
                        n_cmd == 8'h50 || n_cmd == 8'hE0)
                        protset_r <= 1'b1;
                end
                else if (n_op == `FPC_OP_CMD2 && n_cmd == `FPC_CMD_AUTOSEL)
                begin
                    bypass_r  <= 1'b0;
                    protset_r <= 1'b0;
                end
                // Buffer sequence tracking, 2 unlock cycles and the 25 write counted up front as 3
                if (n_op == `FPC_OP_WRITE && wdata_r[7:0] == `FPC_CMD_BUFLOAD && !buf_r)
                begin
                    buf_r     <= 1'b1;
                    buf_wc_r  <= 1'b1;
                    buf_cyc_r <= 6'd3;
                end
                else if (n_op == `FPC_OP_WRITE && buf_r)
                begin
                    buf_cyc_r <= buf_cyc_r + 6'd1; // [R13]
                    if (buf_wc_r)
                    begin
                        buf_wc_r   <= 1'b0;
                        buf_left_r <= wdata_r[7:0] + 8'h01; // [R5]
                    end
                    else if (wdata_r[7:0] == `FPC_CMD_CONFIRM)
                        buf_r <= 1'b0;
                    else
                    begin
                        buf_left_r <= buf_left_r - 8'h01;
                        // Page of the first load binds the later ones
                        if (buf_cyc_r == 6'd4)
                            buf_page_r <= addr_r[`FPC_PAGE_MSB:`FPC_PAGE_LSB]; // [R4]
                    end
                end
            end
        end
    end

    // Flash pin sequencer
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r       <= S_IDLE;
            cnt_r         <= 4'h0;
            step_r        <= 2'd0;
            rdata_r       <= 16'h0000;
            fault_r       <= 1'b0;
            dq_s1_r       <= 16'h0000;
            dq_s2_r       <= 16'h0000;
            o_flash_addr  <= 22'h000000;
            o_flash_dq    <= 16'h0000;
            o_flash_dq_oe <= 1'b0;
            o_flash_ce_n  <= 1'b1;
            o_flash_we_n  <= 1'b1;
            o_flash_oe_n  <= 1'b1;
        end
        else
        begin
            dq_s1_r <= i_flash_dq;
            dq_s2_r <= dq_s1_r;
            case (state_r)
                S_IDLE:
                begin
                    step_r <= 2'd0;
                    if (start)
                        state_r <= S_SETUP;
                end
                S_SETUP:
                begin
                    // Address and CE settle before the strobe falls [R1]
                    o_flash_addr  <= cur_w[37:16];
                    o_flash_dq    <= cur_w[15:0];
                    o_flash_dq_oe <= (op_r != `FPC_OP_READ);
                    o_flash_ce_n  <= 1'b0;
                    state_r       <= S_WE;
                    cnt_r         <= 4'h0;
                end
                S_WE:
                begin
                    if (op_r == `FPC_OP_READ)
                    begin
                        // Plain array or status read [R7] [R10] [R12] [R21]
                        o_flash_oe_n <= 1'b0;
                        state_r      <= S_RD;
                    end
                    else
                    begin
                        o_flash_we_n <= 1'b0;
                        cnt_r        <= cnt_r + 4'h1;
                        if (cnt_r == `FPC_WE_CYC)
                        begin
                            o_flash_we_n <= 1'b1; // [R2]
                            cnt_r        <= 4'h0;
                            state_r      <= S_HOLD;
                        end
                    end
                end
                S_HOLD:
                begin
                    // Data and CE stay past the rising WE [R2]
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == (`FPC_HOLD_CYC) - 1)
                    begin
                        o_flash_ce_n  <= 1'b1;
                        o_flash_dq_oe <= 1'b0;
                        cnt_r         <= 4'h0;
                        state_r       <= S_REC;
                    end
                end
                S_RD:
                begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == (`FPC_ACC_CYC) - 1)
                    begin
                        // Upper byte dropped while in autoselect [R9]
                        rdata_r      <= autosel_r ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
                        fault_r      <= dq_s2_r[5]; // [R8]
                        o_flash_oe_n <= 1'b1;
                        o_flash_ce_n <= 1'b1;
                        cnt_r        <= 4'h0;
                        state_r      <= S_REC;
                    end
                end
                S_REC:
                begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == (`FPC_REC_CYC) - 1)
                    begin
                        cnt_r <= 4'h0;
                        if (step_r == last_step(op_r))
                            state_r <= S_IDLE;
                        else
                        begin
                            step_r  <= step_r + 2'd1;
                            state_r <= S_SETUP;
                        end
                    end
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

endmodule // fpc_ctrl
`default_nettype wire

// ==== fpc_ctrl_checker.sv ====
// Purpose: pin protocol checks on fpc_ctrl
// Assumes: timing picks of fpc_map.vh
// Notes:   bound from the testbench top
`default_nettype none
`include "fpc_map.vh"
module fpc_ctrl_checker
(
    // Clock and reset
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    // Bus reply
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    // Flash pins
    input wire logic [21:0] o_flash_addr,
    input wire logic [15:0] o_flash_dq,
    input wire logic        o_flash_dq_oe,
    input wire logic        o_flash_ce_n,
    input wire logic        o_flash_we_n,
    input wire logic        o_flash_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence s_we_low;
        (!o_flash_we_n)[*5] ##1 o_flash_we_n;
    endsequence
    sequence s_we_hold;
        (!o_flash_ce_n && o_flash_dq_oe && $stable(o_flash_dq))[*2]
            ##1 (o_flash_ce_n && !o_flash_dq_oe);
    endsequence
    sequence s_oe_low;
        (!o_flash_oe_n)[*8] ##1 (!o_flash_oe_n)[*2] ##1 o_flash_oe_n;
    endsequence
    property p_bus_ok;
        $past(i_rst_n) |-> o_hreadyout && !o_hresp;
    endproperty
    property p_setup;
        $fell(o_flash_we_n) |-> !o_flash_ce_n && o_flash_dq_oe && $past(o_flash_ce_n) == 1'h0;
    endproperty
    property p_addr_stable;
        !o_flash_we_n |-> $stable(o_flash_addr) && $stable(o_flash_dq);
    endproperty
    property p_we_width;
        $fell(o_flash_we_n) |-> s_we_low;
    endproperty
    property p_hold;
        $rose(o_flash_we_n) |-> s_we_hold;
    endproperty
    property p_unlock1;
        $fell(o_flash_we_n) && o_flash_dq == `FPC_UNLOCK_D1 |-> o_flash_addr == `FPC_UNLOCK_A1;
    endproperty
    property p_unlock2;
        $fell(o_flash_we_n) && o_flash_dq == `FPC_UNLOCK_D2 |-> o_flash_addr == `FPC_UNLOCK_A2;
    endproperty
    property p_oe_len;
        $fell(o_flash_oe_n) |-> s_oe_low;
    endproperty
    property p_read_side;
        !o_flash_oe_n |-> o_flash_we_n && !o_flash_ce_n && !o_flash_dq_oe;
    endproperty
    property p_idle;
        o_flash_ce_n |-> o_flash_we_n && o_flash_oe_n;
    endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus reply not ready or not okay");
    a_setup: assert property (p_setup) else $error("write strobe without setup");
    a_addr_stable: assert property (p_addr_stable) else $error("addr moved in write");
    a_we_width: assert property (p_we_width) else $error("write pulse width wrong");
    a_hold: assert property (p_hold) else $error("data hold after write wrong");
    a_unlock1: assert property (p_unlock1) else $error("first unlock addr wrong");
    a_unlock2: assert property (p_unlock2) else $error("second unlock addr wrong");
    a_oe_len: assert property (p_oe_len) else $error("read strobe width wrong");
    a_read_side: assert property (p_read_side) else $error("read strobe overlaps drive");
    a_idle: assert property (p_idle) else $error("strobe active while deselected");
endmodule // fpc_ctrl_checker
`default_nettype wire

// ==== fpc_ctrl_tb.sv ====
// Purpose: self-checking bench for fpc_ctrl
// Assumes: zero-wait bus slave, busy polled in status
// Notes:   plain, autoselect and protection sequences
`default_nettype none
`include "fpc_map.vh"
module fpc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        hsel = 1'h0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire         hready;
    wire         hresp;
    wire  [21:0] f_addr;
    wire  [15:0] f_dq;
    wire  [15:0] f_in;
    wire  [15:0] m_q;
    wire         f_oe;
    wire         f_ce_n;
    wire         f_we_n;
    wire         f_oe_n;
    int          fails = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    logic [31:0] v;
    always #5 clk = ~clk;
    assign f_in = f_oe ? f_dq : m_q;
    fpc_ctrl dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .o_flash_addr(f_addr), .o_flash_dq(f_dq), .o_flash_dq_oe(f_oe), .i_flash_dq(f_in),
        .o_flash_ce_n(f_ce_n), .o_flash_we_n(f_we_n), .o_flash_oe_n(f_oe_n));
    fpc_flash_model u_flash (.i_addr(f_addr), .i_dq(f_in), .i_ce_n(f_ce_n),
        .i_we_n(f_we_n), .i_oe_n(f_oe_n), .o_q(m_q));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'h1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        ahb(1'h1, a, d, t);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ahb(1'h0, a, 32'h0, d);
    endtask
    task automatic op(input logic [2:0] o, input logic [7:0] c, input logic [21:0] a,
                      input logic [15:0] d);
        logic [31:0] s;
        wr(`FPC_REG_ADDR, {10'h000, a});
        wr(`FPC_REG_WDATA, {16'h0000, d});
        wr(`FPC_REG_CTRL, {16'h0000, c, 5'h00, o});
        repeat (2) @(posedge clk);
        do rd(`FPC_REG_STATUS, s); while (s[`FPC_ST_BUSY] !== 1'h0);
    endtask
    task automatic fread(input logic [21:0] a, input logic [15:0] e, input string n);
        logic [31:0] r;
        op(`FPC_OP_READ, 8'h00, a, 16'h0000);
        rd(`FPC_REG_RDATA, r);
        chk(n, {16'h0000, e}, r);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fails++;
            complete_run;
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        rd(8'h14, v);
        chk("unmapped", 32'h0, v);
        rd(`FPC_REG_STATUS, v);
        chk("status_reset", 32'h0, v);
        op(`FPC_OP_UNLOCK, 8'hA0, 22'h0, 16'h0);
        op(`FPC_OP_WRITE, 8'h00, 22'h10, 16'h1234);
        fread(22'h10, 16'h1234, "array");
        op(`FPC_OP_CMD2, 8'hA0, 22'h10, 16'h0);
        rd(`FPC_REG_STATUS, v);
        chk("refused_a0", 32'h2, v & 32'h2);
        op(`FPC_OP_UNLOCK, 8'hC0, 22'h0, 16'h0);
        rd(`FPC_REG_STATUS, v);
        chk("prot_set", 32'h20, v & 32'h22);
        op(`FPC_OP_WRITE, 8'h00, 22'h55, 16'h98);
        rd(`FPC_REG_STATUS, v);
        chk("refused_98", 32'h2, v & 32'h2);
        op(`FPC_OP_CMD2, 8'hA0, 22'h018000, 16'h0);
        fread(22'h018000, 16'h0, "ppb_on");
        fread(22'h020000, 16'h1, "ppb_off");
        op(`FPC_OP_CMD2, 8'h90, 22'h0, 16'h0);
        fread(22'h10, 16'h1234, "pair_exit");
        op(`FPC_OP_UNLOCK, 8'h90, 22'h0, 16'h0);
        fread(22'h018004, 16'h0001, "verify");
        op(`FPC_OP_RESET, 8'h00, 22'h0, 16'h0);
        fread(22'h10, 16'h1234, "reset_exit");
        op(`FPC_OP_UNLOCK, 8'hC0, 22'h0, 16'h0);
        op(`FPC_OP_CMD2, 8'h80, 22'h0, 16'h30);
        fread(22'h018000, 16'h1, "ppb_erase");
        op(`FPC_OP_RESET, 8'h00, 22'h0, 16'h0);
        op(`FPC_OP_UNLOCK, 8'h50, 22'h0, 16'h0);
        op(`FPC_OP_CMD2, 8'hA0, 22'h0, 16'h0);
        fread(22'h3FFFFF, 16'h1, "freeze");
        op(`FPC_OP_RESET, 8'h00, 22'h0, 16'h0);
        fread(22'h10, 16'h1234, "f0_exit");
        op(`FPC_OP_UNLOCK, 8'hE0, 22'h0, 16'h0);
        op(`FPC_OP_CMD2, 8'hA0, 22'h028000, 16'h0);
        fread(22'h028000, 16'h0, "dyb_set");
        op(`FPC_OP_CMD2, 8'hA0, 22'h028000, 16'h1);
        fread(22'h028000, 16'h1, "dyb_clr");
        op(`FPC_OP_RESET, 8'h00, 22'h0, 16'h0);
        op(`FPC_OP_WRITE, 8'h00, 22'h55, 16'h98);
        fread(22'h10, 16'h00C3, "query");
        op(`FPC_OP_RESET, 8'h00, 22'h0, 16'h0);
        op(`FPC_OP_UNLOCK, 8'h20, 22'h0, 16'h0);
        op(`FPC_OP_CMD2, 8'hA0, 22'h20, 16'h5678);
        fread(22'h20, 16'h5678, "bypass_prog");
        op(`FPC_OP_RESET, 8'h00, 22'h0, 16'h0);
        op(`FPC_OP_WRITE, 8'h00, 22'h555, 16'hAA);
        op(`FPC_OP_WRITE, 8'h00, 22'h2AA, 16'h55);
        op(`FPC_OP_WRITE, 8'h00, 22'h40, 16'h25);
        op(`FPC_OP_WRITE, 8'h00, 22'h40, 16'h1);
        op(`FPC_OP_WRITE, 8'h00, 22'h80, 16'h11);
        rd(`FPC_REG_STATUS, v);
        chk("buf_first", 32'h40, v & 32'h42);
        op(`FPC_OP_WRITE, 8'h00, 22'h100, 16'h12);
        rd(`FPC_REG_STATUS, v);
        chk("buf_page", 32'h42, v & 32'h42);
        op(`FPC_OP_WRITE, 8'h00, 22'h80, 16'h29);
        wr(`FPC_REG_CTRL, {24'h0, 5'h00, `FPC_OP_RESET});
        @(posedge clk);
        wr(`FPC_REG_CTRL, {24'h0, 5'h00, `FPC_OP_RESET});
        rd(`FPC_REG_STATUS, v);
        chk("busy_refuse", 32'h1, v & 32'h3);
        complete_run;
    end
endmodule // fpc_ctrl_tb
bind fpc_ctrl fpc_ctrl_checker u_chk (.*);
`default_nettype wire

// ==== fpc_flash_model.sv ====
// Purpose: behavioural flash device facing fpc_ctrl
// Assumes: x16 part, uniform sectors of 32K words
// Notes:   undriven bus shows inverse of last read
`default_nettype none
module fpc_flash_model
(
    // Pins from controller
    input  wire logic [21:0] i_addr,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    // Read data
    output wire logic [15:0] o_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0]  mem [0:255];
    logic [127:0] persistent_protect_bit = '0;
    logic [127:0] volatile_protect_bit = '0;
    logic         frz = 1'h0;
    logic [7:0]   mode = 8'h00;
    logic [7:0]   pend = 8'h00;
    logic [1:0]   stg = 2'h0;
    logic [21:0]  la;
    logic [15:0]  rdv;
    logic [15:0]  last_q;
    wire          wr = i_we_n | i_ce_n;
    wire          rd_en = !i_ce_n && !i_oe_n;
    wire  [6:0]   sec = i_addr[21:15];
    always @(negedge wr) la = i_addr;
    always @(posedge wr)
    begin : take
        logic [7:0] d;
        d = i_dq[7:0];
        if (d == 8'hF0)
        begin
            mode = 8'h00;
            pend = 8'h00;
            stg = 2'h0;
        end
        else if (pend == 8'hA0)
        begin
            if (mode == 8'hC0) persistent_protect_bit[la[21:15]] = 1'h1;
            if (mode == 8'hE0) volatile_protect_bit[la[21:15]] = ~i_dq[0];
            if (mode == 8'h50) frz = 1'h1;
            if (mode == 8'h20) mem[la[7:0]] = i_dq;
            pend = 8'h00;
        end
        else if (pend == 8'h80)
        begin
            if (d == 8'h30 && mode == 8'hC0) persistent_protect_bit = '1;
            if (d == 8'h30 && mode == 8'hC0) persistent_protect_bit = '0;
            pend = 8'h00;
        end
        else if (pend == 8'h90)
        begin
            if (d == 8'h00) mode = 8'h00;
            pend = 8'h00;
        end
        else if (mode == 8'hA0)
        begin
            mem[la[7:0]] = i_dq;
            mode = 8'h00;
        end
        else if (d == 8'h98 && (mode == 8'h00 || mode == 8'h90)) mode = 8'h98;
        else if (mode != 8'h00 && mode != 8'h90) pend = d;
        else if (stg == 2'h2 && la[10:0] == 11'h555) {mode, stg} = {d, 2'h0};
        else if (stg == 2'h1 && la[10:0] == 11'h2AA && d == 8'h55) stg = 2'h2;
        else stg = (la[10:0] == 11'h555 && d == 8'hAA) ? 2'h1 : 2'h0;
    end
    always @*
        case (mode)
            8'h90: rdv = (i_addr[7:0] == 8'h04) ? {8'hA5, 7'h00, persistent_protect_bit[sec]} : 16'hA5A5;
            8'hC0: rdv = {15'h0000, ~persistent_protect_bit[sec]};
            8'hE0: rdv = {15'h0000, ~volatile_protect_bit[sec]};
            8'h50: rdv = {15'h0000, frz};
            8'h98: rdv = 16'h00C3; // Arbitrary query reply
            default: rdv = mem[i_addr[7:0]];
        endcase
    always @*
        if (rd_en)
            last_q = rdv;
    assign o_q = rd_en ? rdv : ~last_q;
endmodule // fpc_flash_model
`default_nettype wire

// ==== fpc_map.vh ====
// Purpose: constants for the flash protection command controller
// Assumes: 100 MHz system clock, x16 flash, 22 word-address lines
// Notes:   times in ns, cycle counts derived from them
`ifndef FPC_MAP_VH
`define FPC_MAP_VH

// Register byte offsets
`define FPC_REG_CTRL     8'h00
`define FPC_REG_ADDR     8'h04
`define FPC_REG_WDATA    8'h08
`define FPC_REG_RDATA    8'h0C
`define FPC_REG_STATUS   8'h10

// Control fields
`define FPC_CTRL_OP_LSB  0
`define FPC_CTRL_OP_MSB  2
`define FPC_CTRL_CMD_LSB 8
`define FPC_CTRL_CMD_MSB 15

// Operation codes
`define FPC_OP_WRITE     3'h0
`define FPC_OP_READ      3'h1
`define FPC_OP_UNLOCK    3'h2
`define FPC_OP_CMD2      3'h3
`define FPC_OP_RESET     3'h4

// Status bit positions
`define FPC_ST_BUSY      0
`define FPC_ST_REFUSED   1
`define FPC_ST_FAULT     2
`define FPC_ST_DQ0       3
`define FPC_ST_BYPASS    4
`define FPC_ST_PROTSET   5
`define FPC_ST_BUFFER    6

// Flash command codes and unlock addresses
`define FPC_UNLOCK_A1    22'h000555
`define FPC_UNLOCK_A2    22'h0002AA
`define FPC_UNLOCK_D1    16'h00AA
`define FPC_UNLOCK_D2    16'h0055
`define FPC_CMD_RESET    8'hF0
`define FPC_CMD_BUFLOAD  8'h25
`define FPC_CMD_CONFIRM  8'h29
`define FPC_CMD_BYPASS   8'h20
`define FPC_CMD_AUTOSEL  8'h90
`define FPC_CMD_QUERY    8'h98
`define FPC_CMD_PROG     8'hA0
`define FPC_BUF_MAX_CYC  6'd37
`define FPC_PAGE_MSB     21
`define FPC_PAGE_LSB     7

// Timing
`define FPC_CLK_NS       10
`define FPC_T_WE_NS      50
`define FPC_T_HOLD_NS    20
`define FPC_T_REC_NS     30
`define FPC_T_ACC_NS     80
`define FPC_WE_CYC       (((`FPC_T_WE_NS) + (`FPC_CLK_NS) - 1) / (`FPC_CLK_NS))
`define FPC_HOLD_CYC     (((`FPC_T_HOLD_NS) + (`FPC_CLK_NS) - 1) / (`FPC_CLK_NS))
`define FPC_REC_CYC      (((`FPC_T_REC_NS) + (`FPC_CLK_NS) - 1) / (`FPC_CLK_NS))
`define FPC_ACC_CYC      ((((`FPC_T_ACC_NS) + (`FPC_CLK_NS) - 1) / (`FPC_CLK_NS)) + 2)

`endif
